/* File: verilog/dcpwu_consts.vh */
// Purpose: constants for the dual channel pulse width unit
// Assumes: 8-bit special function register port
// Notes: definitions only
`ifndef DCPWU_CONSTS_VH
`define DCPWU_CONSTS_VH
`define DCPWU_ADDR_DUTY0 8'hfc
`define DCPWU_ADDR_DUTY1 8'hfd
`define DCPWU_ADDR_PRESCALE 8'hfe
`define DCPWU_RESET_BYTE 8'h00
`define DCPWU_COUNT_LAST 8'hfe
`define DCPWU_COUNT_ZERO 8'h00
`define DCPWU_ONE 8'h01
`define DCPWU_OSC_DIV 1'b1
`define DCPWU_PULSE_IDLE 1'b1
`define DCPWU_HIT_IDLE 1'b0
`define DCPWU_HIT_ON 1'b1
`define DCPWU_PAD_BIT 1'b0
`define DCPWU_SEL_NONE 3'b000
`define DCPWU_SEL_DUTY0 3'b001
`define DCPWU_SEL_DUTY1 3'b010
`define DCPWU_SEL_PRESCALE 3'b100
`endif

/* File: verilog/dcpwu_compare.v */
// Purpose: one output channel, duty compare against shared count
// Assumes: count and duty are on core_clk
// Notes: output registered
`default_nettype none
`include "dcpwu_consts.vh"
module dcpwu_compare (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // compare operands
   input wire [7:0] duty,
   input wire [7:0] count,
   // channel output
   output reg pulse_out
);
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pulse_out <= `DCPWU_PULSE_IDLE;
      end else begin
         // 00 always high, ff always low
         pulse_out <= !(duty > count);
      end
   end
endmodule // dcpwu_compare
`default_nettype wire

/* File: verilog/dcpwu_top.v */
// Purpose: two-channel pulse width modulator with shared prescaler and counter
// Assumes: core_clk is the oscillator clock; registers reached by an 8-bit sfr port
// Notes: reads return registered data one cycle after the read strobe
`default_nettype none
`include "dcpwu_consts.vh"
module dcpwu_top (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // special function register port
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   output reg sfr_hit,
   // pulse outputs
   output wire pulse_output_channel0,
   output wire pulse_output_channel1
);
   // register select codes, one hot
   localparam [2:0] SEL_NONE = `DCPWU_SEL_NONE;
   localparam [2:0] SEL_DUTY0 = `DCPWU_SEL_DUTY0;
   localparam [2:0] SEL_DUTY1 = `DCPWU_SEL_DUTY1;
   localparam [2:0] SEL_PRESCALE = `DCPWU_SEL_PRESCALE;
   localparam integer CHANNELS = 2;

   // software visible registers
   reg [7:0] duty_ratio_channel0;
   reg [7:0] duty_ratio_channel1;
   reg [7:0] rate_prescale_divider;
   reg [7:0] next_duty_ratio_channel0;
   reg [7:0] next_duty_ratio_channel1;
   reg [7:0] next_rate_prescale_divider;
   // read port next values
   reg [7:0] next_sfr_rdata;
   reg next_sfr_hit;
   // shared timebase
   reg osc_half;
   reg [7:0] prescale_count;
   reg [7:0] shared_count;
   reg next_osc_half;
   reg [7:0] next_prescale_count;
   reg [7:0] next_shared_count;
   wire [8:0] prescale_sum;
   wire [8:0] count_sum;
   wire prescale_done;
   wire count_wrap;
   wire count_step;
   // address decode
   wire [2:0] wr_sel;
   wire [2:0] rd_sel;
   // channel fan out
   wire [CHANNELS*8-1:0] duty_bus;
   wire [CHANNELS-1:0] pulse_bus;

   // one-hot select of the addressed register, none if unmapped
   function [2:0] reg_select;
      input [7:0] a;
      begin
         case (a)
            `DCPWU_ADDR_DUTY0: begin
               reg_select = SEL_DUTY0;
            end
            `DCPWU_ADDR_DUTY1: begin
               reg_select = SEL_DUTY1;
            end
            `DCPWU_ADDR_PRESCALE: begin
               reg_select = SEL_PRESCALE;
            end
            default: begin
               reg_select = SEL_NONE;
            end
         endcase
      end
   endfunction

   assign wr_sel = sfr_wr ? reg_select(sfr_addr) : SEL_NONE;
   assign rd_sel = sfr_rd ? reg_select(sfr_addr) : SEL_NONE;

   // unmapped writes leave every register untouched
   always @* begin
      next_duty_ratio_channel0 = duty_ratio_channel0;
      next_duty_ratio_channel1 = duty_ratio_channel1;
      next_rate_prescale_divider = rate_prescale_divider;
      case (wr_sel)
         SEL_DUTY0: begin
            next_duty_ratio_channel0 = sfr_wdata;
         end
         SEL_DUTY1: begin
            next_duty_ratio_channel1 = sfr_wdata;
         end
         SEL_PRESCALE: begin
            next_rate_prescale_divider = sfr_wdata;
         end
         default: begin
            next_rate_prescale_divider = rate_prescale_divider;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         duty_ratio_channel0 <= `DCPWU_RESET_BYTE;
         duty_ratio_channel1 <= `DCPWU_RESET_BYTE;
         rate_prescale_divider <= `DCPWU_RESET_BYTE;
      end else begin
         duty_ratio_channel0 <= next_duty_ratio_channel0;
         duty_ratio_channel1 <= next_duty_ratio_channel1;
         rate_prescale_divider <= next_rate_prescale_divider;
      end
   end

   always @* begin
      next_sfr_rdata = `DCPWU_RESET_BYTE;
      next_sfr_hit = `DCPWU_HIT_IDLE;
      case (rd_sel)
         SEL_DUTY0: begin
            next_sfr_rdata = duty_ratio_channel0;
            next_sfr_hit = `DCPWU_HIT_ON;
         end
         SEL_DUTY1: begin
            next_sfr_rdata = duty_ratio_channel1;
            next_sfr_hit = `DCPWU_HIT_ON;
         end
         SEL_PRESCALE: begin
            next_sfr_rdata = rate_prescale_divider;
            next_sfr_hit = `DCPWU_HIT_ON;
         end
         default: begin
            next_sfr_hit = `DCPWU_HIT_IDLE;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         sfr_rdata <= `DCPWU_RESET_BYTE;
         sfr_hit <= `DCPWU_HIT_IDLE;
      end else begin
         sfr_rdata <= next_sfr_rdata;
         sfr_hit <= next_sfr_hit;
      end
   end

   // modulo 255 count
   // >= lets a smaller prescale value act without a restart
   assign prescale_done = (prescale_count >= rate_prescale_divider);
   assign count_wrap = (shared_count >= `DCPWU_COUNT_LAST);
   assign count_step = osc_half && prescale_done;
   assign prescale_sum = {`DCPWU_PAD_BIT, prescale_count} + {`DCPWU_PAD_BIT, `DCPWU_ONE};
   assign count_sum = {`DCPWU_PAD_BIT, shared_count} + {`DCPWU_PAD_BIT, `DCPWU_ONE};

   always @* begin
      next_osc_half = osc_half ^ `DCPWU_OSC_DIV;
      next_prescale_count = prescale_count;
      next_shared_count = shared_count;
      if (osc_half) begin
         if (prescale_done) begin
            next_prescale_count = `DCPWU_COUNT_ZERO;
         end else begin
            next_prescale_count = prescale_sum[7:0];
         end
      end
      if (count_step) begin
         if (count_wrap) begin
            next_shared_count = `DCPWU_COUNT_ZERO;
         end else begin
            next_shared_count = count_sum[7:0];
         end
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         osc_half <= `DCPWU_PAD_BIT;
         prescale_count <= `DCPWU_COUNT_ZERO;
         shared_count <= `DCPWU_COUNT_ZERO;
      end else begin
         osc_half <= next_osc_half;
         prescale_count <= next_prescale_count;
         shared_count <= next_shared_count;
      end
   end

   assign duty_bus = {duty_ratio_channel1, duty_ratio_channel0};

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_channel
         dcpwu_compare u_ch (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .duty(duty_bus[ch*8 +: 8]),
            .count(shared_count),
            .pulse_out(pulse_bus[ch])
         );
      end
   endgenerate

   assign pulse_output_channel0 = pulse_bus[0];
   assign pulse_output_channel1 = pulse_bus[1];
endmodule // dcpwu_top
`default_nettype wire

/* File: tb/dcpwu_top_sva.sv */
// Purpose: port checks. Assumes: sync reset. Notes: bound to dcpwu_top
`default_nettype none
module dcpwu_sva (
   input wire logic core_clk, sys_rst, sfr_wr, sfr_rd, sfr_hit,
   input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
   input wire logic pulse_output_channel0, pulse_output_channel1
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire logic mapped = sfr_addr > 8'hfb && sfr_addr < 8'hff;
   a_read_hit: assert property (sfr_rd && mapped |=> sfr_hit) else $error("no hit");
   a_unmapped_read: assert property (sfr_rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
      else $error("unmapped read answered");
   a_idle_clear: assert property (!sfr_rd |=> !sfr_hit && sfr_rdata == 8'h00) else $error("stale read");
   a_write_read: assert property (sfr_wr && sfr_addr == 8'hfc ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'hfc
      |=> sfr_rdata == $past(sfr_wdata, 3)) else $error("read not last write");
   a_zero_high: assert property (sfr_wr && sfr_addr == 8'hfc && sfr_wdata == 8'h00 ##1 !(sfr_wr && sfr_addr == 8'hfc)
      |=> pulse_output_channel0) else $error("duty 00 not high");
   a_full_low: assert property (sfr_wr && sfr_addr == 8'hfd && sfr_wdata == 8'hff ##1 !(sfr_wr && sfr_addr == 8'hfd)
      |=> !pulse_output_channel1) else $error("duty ff not low");
   a_high_hold: assert property ($rose(pulse_output_channel0) && !$past(sfr_wr) && !$past(sfr_wr, 2)
      |=> pulse_output_channel0) else $error("high too short");
   a_low_hold: assert property ($fell(pulse_output_channel1) && !$past(sfr_wr) && !$past(sfr_wr, 2)
      |=> !pulse_output_channel1) else $error("low too short");
endmodule // dcpwu_sva
bind dcpwu_top dcpwu_sva u_sva (.core_clk, .sys_rst, .sfr_wr, .sfr_rd, .sfr_hit, .sfr_addr, .sfr_wdata,
   .sfr_rdata, .pulse_output_channel0, .pulse_output_channel1);
`default_nettype wire

/* File: tb/dcpwu_load.sv */
// Purpose: load on both pulse pins. Assumes: core_clk. Notes: counts low and unequal cycles
`default_nettype none
module dcpwu_load (
   input wire logic core_clk, clr, a, b,
   output var int low_a, low_b, diff
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge core_clk) begin
      low_a <= clr ? 0 : low_a + int'(!a);
      low_b <= clr ? 0 : low_b + int'(!b);
      diff <= clr ? 0 : diff + int'(a != b);
   end
endmodule // dcpwu_load
`default_nettype wire

/* File: tb/dcpwu_test.sv */
// Purpose: register and pulse tests. Assumes: 10 MHz clock. Notes: fixed windows only
`default_nettype none
module dual_channel_pulse_width_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, sys_rst, wr, rd, clr;
   logic [7:0] addr, wd;
   wire [7:0] rdata;
   wire hit, p0, p1;
   int errors, checked, la, lb, df;
   dcpwu_top dut (.core_clk, .sys_rst, .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd),
      .sfr_rdata(rdata), .sfr_hit(hit), .pulse_output_channel0(p0), .pulse_output_channel1(p1));
   dcpwu_load load (.core_clk, .clr, .a(p0), .b(p1), .low_a(la), .low_b(lb), .diff(df));
   task chk8(input logic [7:0] g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected %0t byte %h want %h", $time, g, e);
      end
   endtask
   task chkn(input int g, e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("unexpected %0t count %0d want %0d", $time, g, e);
      end
   endtask
   task wr_reg(input logic [7:0] a, d);
      addr <= a; wd <= d; wr <= 1'b1;
      @(posedge core_clk) wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd_reg(input logic [7:0] a, e);
      addr <= a; rd <= 1'b1;
      @(posedge core_clk) rd <= 1'b0;
      @(negedge core_clk);
      chk8(rdata, e);
      chk8({7'h00, hit}, {7'h00, a > 8'hfb && a < 8'hff});
      @(posedge core_clk);
   endtask
   // one full period of low and unequal cycles
   task meas(input int n, ea, eb, ed);
      repeat (4) @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk) clr <= 1'b0;
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
      chkn(la, ea);
      chkn(lb, eb);
      chkn(df, ed);
      @(posedge core_clk);
   endtask
   task conclude;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      errors = 0; checked = 0; sys_rst = 1'b1; wr = 1'b0; rd = 1'b0; clr = 1'b1; addr = 8'h00; wd = 8'h00;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 252; i < 255; i++) rd_reg(8'(i), 8'h00);
      wr_reg(8'hfe, 8'h01);
      wr_reg(8'hfd, 8'h80);
      wr_reg(8'hfc, 8'h80);
      rd_reg(8'hfc, 8'h80);
      wr_reg(8'hff, 8'h55);
      rd_reg(8'hfe, 8'h01);
      rd_reg(8'hfb, 8'h00);
      meas(1020, 512, 512, 0);
      wr_reg(8'hfc, 8'h00);
      wr_reg(8'hfd, 8'hff);
      meas(1020, 0, 1020, 1020);
      wr_reg(8'hfe, 8'h00);
      wr_reg(8'hfc, 8'h01);
      wr_reg(8'hfd, 8'hfe);
      meas(510, 2, 508, 506);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk8({6'h00, p1, p0}, 8'h03);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      rd_reg(8'hfc, 8'h00);
      rd_reg(8'hfe, 8'h00);
      conclude();
   end
endmodule // dual_channel_pulse_width_unit_test
`default_nettype wire
